// ==== ctp_pkg.sv ====
// constants and types shared by the counter/timer block
package ctp_pkg;

    // register byte offsets
    localparam logic [5:0] CTP_OFF_CLKCTL = 6'h00;
    localparam logic [5:0] CTP_OFF_MODE   = 6'h04;
    localparam logic [5:0] CTP_OFF_RUN    = 6'h08;
    localparam logic [5:0] CTP_OFF_CNT0   = 6'h0c;
    localparam logic [5:0] CTP_OFF_CNT1   = 6'h10;
    localparam logic [5:0] CTP_OFF_CNT2   = 6'h14;
    localparam logic [5:0] CTP_OFF_RLD2   = 6'h18;
    localparam logic [5:0] CTP_OFF_STATUS = 6'h1c;
    localparam logic [5:0] CTP_OFF_MASK   = 6'h20;

    // clock control field positions
    localparam int CTP_CK_PRESCALE = 0;
    localparam int CTP_CK_T0SEL    = 2;
    localparam int CTP_CK_T1SEL    = 3;
    localparam int CTP_CK_T2SRC    = 4;
    localparam int CTP_CK_T2HSYS   = 6;
    // mode register field positions
    localparam int CTP_MD_MODE0    = 0;
    localparam int CTP_MD_CT0      = 2;
    localparam int CTP_MD_GATE_BIT_ZERO    = 3;
    localparam int CTP_MD_MODE1    = 4;
    localparam int CTP_MD_CT1      = 6;
    localparam int CTP_MD_GATE1    = 7;
    localparam int CTP_MD_POL0     = 8;
    localparam int CTP_MD_POL1     = 9;
    // run register field positions
    localparam int CTP_RN_RUN0     = 0;
    localparam int CTP_RN_RUN1     = 1;
    localparam int CTP_RN_RUN2     = 2;
    localparam int CTP_RN_SPLIT2   = 3;

    // reset values
    localparam logic [6:0]  CTP_RST_CLKCTL = 7'h00;
    localparam logic [9:0]  CTP_RST_MODE   = 10'h000;
    localparam logic [3:0]  CTP_RST_RUN    = 4'h0;
    localparam logic [15:0] CTP_RST_CNT    = 16'h0000;
    localparam logic [3:0]  CTP_RST_STATUS = 4'h0;
    localparam logic [3:0]  CTP_RST_MASK   = 4'h0;

    // divider counts, in system clock cycles, /12 ticks or external edges
    localparam logic [1:0] CTP_DIV4_LAST   = 2'h3;
    localparam logic [3:0] CTP_DIV12_LAST  = 4'hb;
    localparam logic [1:0] CTP_DIV48_LAST  = 2'h3;
    localparam logic [2:0] CTP_DIVX_LAST   = 3'h7;

    // shared prescale codes
    localparam logic [1:0] CTP_PS_DIV12    = 2'h0;
    localparam logic [1:0] CTP_PS_DIV4     = 2'h1;
    localparam logic [1:0] CTP_PS_DIV48    = 2'h2;
    // third timer source codes, other values pick the system clock
    localparam logic [1:0] CTP_T2_DIV12    = 2'h0;
    localparam logic [1:0] CTP_T2_EXT8     = 2'h1;

    typedef enum logic [1:0] {
        CTP_M13,
        CTP_M16,
        CTP_M8R,
        CTP_MSPLIT
    } ctp_mode_e;

endpackage : ctp_pkg

// ==== ctp_timers.sv ====
// three counter/timers with shared prescaler and avalon-mm registers
`timescale 1ns/1ps

module ctp_timers
    import ctp_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        event_input_zero_i,
    input  wire logic        event_input_one_i,
    input  wire logic        gating_input_zero_i,
    input  wire logic        gating_input_one_i,
    input  wire logic        external_oscillator_clock_i,
    output logic             irq_o,
    output logic             baud_tick_o
);

    function automatic logic [31:0] ctp_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
        for (int i = 0; i < 4; i++) begin
            ctp_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : ctp_merge

    // overflow in bit 16, new count below
    function automatic logic [16:0] ctp_step(input ctp_mode_e m,
                                             input logic [15:0] c);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0]  s8;
        s13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
        s16 = {1'b0, c} + 17'h00001;
        s8  = {1'b0, c[7:0]} + 9'h001;
        case (m)
            CTP_M13: ctp_step = {s13[13], s13[12:5], c[7:5], s13[4:0]};
            CTP_M16: ctp_step = s16;
            CTP_M8R: ctp_step = {s8[8], c[15:8], s8[8] ? c[15:8] : s8[7:0]};
            default: ctp_step = {s8[8], c[15:8], s8[7:0]};
        endcase
    endfunction : ctp_step

    logic [6:0]  clkctl;
    logic [9:0]  modereg;
    logic [3:0]  runreg;
    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic [15:0] rld2;
    logic [3:0]  status;
    logic [3:0]  mask;

    // bus handshake: one wait cycle, then the request is taken
    logic        req;
    logic        wr_en;
    logic        rd_take;
    logic [31:0] rdata;
    assign req     = avs_read_i | avs_write_i;
    assign wr_en   = avs_write_i & ~avs_waitrequest_o;
    assign rd_take = avs_read_i & avs_waitrequest_o;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
        end
    end

    // field views
    logic [1:0] prescale;
    logic       t0_sel;
    logic       t1_sel;
    logic [1:0] t2_src;
    logic       t2h_sys;
    ctp_mode_e  mode0;
    ctp_mode_e  mode1;
    logic       ct0;
    logic       ct1;
    logic       gate_bit_zero;
    logic       gate1;
    logic       pol0;
    logic       pol1;
    logic       run0;
    logic       run1;
    logic       run2;
    logic       split2;
    assign prescale = clkctl[CTP_CK_PRESCALE +: 2];
    assign t0_sel   = clkctl[CTP_CK_T0SEL];
    assign t1_sel   = clkctl[CTP_CK_T1SEL];
    assign t2_src   = clkctl[CTP_CK_T2SRC +: 2];
    assign t2h_sys  = clkctl[CTP_CK_T2HSYS];
    assign mode0    = ctp_mode_e'(modereg[CTP_MD_MODE0 +: 2]);
    assign mode1    = ctp_mode_e'(modereg[CTP_MD_MODE1 +: 2]);
    assign ct0      = modereg[CTP_MD_CT0];
    assign ct1      = modereg[CTP_MD_CT1];
    assign gate_bit_zero    = modereg[CTP_MD_GATE_BIT_ZERO];
    assign gate1    = modereg[CTP_MD_GATE1];
    assign pol0     = modereg[CTP_MD_POL0];
    assign pol1     = modereg[CTP_MD_POL1];
    assign run0     = runreg[CTP_RN_RUN0];
    assign run1     = runreg[CTP_RN_RUN1];
    assign run2     = runreg[CTP_RN_RUN2];
    assign split2   = runreg[CTP_RN_SPLIT2];

    // merged write values
    logic [31:0] m_clk;
    logic [31:0] m_mode;
    logic [31:0] m_run;
    logic [31:0] m_cnt0;
    logic [31:0] m_cnt1;
    logic [31:0] m_cnt2;
    logic [31:0] m_rld2;
    logic [31:0] m_mask;
    assign m_clk  = ctp_merge({25'h0, clkctl}, avs_writedata_i, avs_byteenable_i);
    assign m_mode = ctp_merge({22'h0, modereg}, avs_writedata_i, avs_byteenable_i);
    assign m_run  = ctp_merge({28'h0, runreg}, avs_writedata_i, avs_byteenable_i);
    assign m_cnt0 = ctp_merge({16'h0, cnt0}, avs_writedata_i, avs_byteenable_i);
    assign m_cnt1 = ctp_merge({16'h0, cnt1}, avs_writedata_i, avs_byteenable_i);
    assign m_cnt2 = ctp_merge({16'h0, cnt2}, avs_writedata_i, avs_byteenable_i);
    assign m_rld2 = ctp_merge({16'h0, rld2}, avs_writedata_i, avs_byteenable_i);
    assign m_mask = ctp_merge({28'h0, mask}, avs_writedata_i, avs_byteenable_i);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clkctl  <= CTP_RST_CLKCTL;
            modereg <= CTP_RST_MODE;
            runreg  <= CTP_RST_RUN;
            rld2    <= CTP_RST_CNT;
            mask    <= CTP_RST_MASK;
        end else if (wr_en) begin
            if (avs_address_i == CTP_OFF_CLKCTL) begin
                clkctl <= m_clk[6:0];
            end else if (avs_address_i == CTP_OFF_MODE) begin
                modereg <= m_mode[9:0];
            end else if (avs_address_i == CTP_OFF_RUN) begin
                runreg <= m_run[3:0];
            end else if (avs_address_i == CTP_OFF_RLD2) begin
                rld2 <= m_rld2[15:0];
            end else if (avs_address_i == CTP_OFF_MASK) begin
                mask <= m_mask[3:0];
            end
        end
    end

    // input synchronisers; first stage feeds only the second
    logic ev0_s1, ev0_s2, ev0_s3;
    logic ev1_s1, ev1_s2, ev1_s3;
    logic g0_s1, g0_s2, g1_s1, g1_s2;
    logic ex_s1, ex_s2, ex_s3;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {ev0_s1, ev0_s2, ev0_s3} <= 3'h0;
            {ev1_s1, ev1_s2, ev1_s3} <= 3'h0;
            {g0_s1, g0_s2, g1_s1, g1_s2} <= 4'h0;
            {ex_s1, ex_s2, ex_s3} <= 3'h0;
        end else begin
            {ev0_s1, ev0_s2, ev0_s3} <= {event_input_zero_i, ev0_s1, ev0_s2};
            {ev1_s1, ev1_s2, ev1_s3} <= {event_input_one_i, ev1_s1, ev1_s2};
            {g0_s1, g0_s2} <= {gating_input_zero_i, g0_s1};
            {g1_s1, g1_s2} <= {gating_input_one_i, g1_s1};
            {ex_s1, ex_s2, ex_s3} <= {external_oscillator_clock_i, ex_s1, ex_s2};
        end
    end

    // edge detect keeps up with one event per two clocks at best
    logic ev0_fall;
    logic ev1_fall;
    logic ex_rise;
    assign ev0_fall = ev0_s3 & ~ev0_s2;
    assign ev1_fall = ev1_s3 & ~ev1_s2;
    assign ex_rise  = ex_s2 & ~ex_s3;

    // prescaler: /4 and /12 free running, /48 from /12, external /8
    logic [1:0] div4;
    logic [3:0] div12;
    logic [1:0] div48;
    logic [2:0] divx;
    logic tick4, tick12, tick48, tickx, pre_tick;
    assign tick4  = div4 == CTP_DIV4_LAST;
    assign tick12 = div12 == CTP_DIV12_LAST;
    assign tick48 = tick12 && div48 == CTP_DIV48_LAST;
    assign tickx  = ex_rise && divx == CTP_DIVX_LAST;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div4  <= 2'h0;
            div12 <= 4'h0;
            div48 <= 2'h0;
            divx  <= 3'h0;
        end else begin
            div4  <= div4 + 2'h1;
            div12 <= tick12 ? 4'h0 : div12 + 4'h1;
            if (tick12) begin
                div48 <= div48 + 2'h1;
            end
            if (ex_rise) begin
                divx <= divx + 3'h1;
            end
        end
    end

    always_comb begin
        case (prescale)
            CTP_PS_DIV12: pre_tick = tick12;
            CTP_PS_DIV4:  pre_tick = tick4;
            CTP_PS_DIV48: pre_tick = tick48;
            default:      pre_tick = tickx;
        endcase
    end

    // timer clocks and enables
    logic tick0, tick1, t1_tclk, en0, en1, th0_go;
    assign tick0   = ct0 ? ev0_fall : (t0_sel | pre_tick);
    assign t1_tclk = t1_sel | pre_tick;
    assign tick1   = ct1 ? ev1_fall : t1_tclk;
    assign en0     = run0 & (~gate_bit_zero | (g0_s2 == pol0));
    assign en1     = run1 & (~gate1 | (g1_s2 == pol1)) & (mode1 != CTP_MSPLIT);
    // split timer zero: upper byte borrows run and clock of timer one
    assign th0_go  = mode0 == CTP_MSPLIT && run1 && t1_tclk;

    logic [16:0] st0;
    logic [16:0] st1;
    logic [8:0]  th0_inc;
    logic        ovf0_ev, th0_ev, ovf1_ev;
    logic [15:0] next_cnt0;
    logic [15:0] next_cnt1;
    assign st0     = ctp_step(mode0, cnt0);
    assign st1     = ctp_step(mode1, cnt1);
    assign th0_inc = {1'b0, cnt0[15:8]} + 9'h001;
    assign ovf0_ev = tick0 & en0 & st0[16];
    assign th0_ev  = th0_go & th0_inc[8];
    assign ovf1_ev = tick1 & en1 & st1[16];

    always_comb begin
        next_cnt0 = cnt0;
        if (tick0 && en0) begin
            next_cnt0 = st0[15:0];
        end
        if (th0_go) begin
            next_cnt0[15:8] = th0_inc[7:0];
        end
        next_cnt1 = cnt1;
        if (tick1 && en1) begin
            next_cnt1 = st1[15:0];
        end
    end

    // software writes override counting in the same cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt0 <= CTP_RST_CNT;
            cnt1 <= CTP_RST_CNT;
        end else begin
            cnt0 <= (wr_en && avs_address_i == CTP_OFF_CNT0) ? m_cnt0[15:0] : next_cnt0;
            cnt1 <= (wr_en && avs_address_i == CTP_OFF_CNT1) ? m_cnt1[15:0] : next_cnt1;
        end
    end

    // third timer
    logic        tick2, tick2h, ovf2l_ev, ovf2h_ev;
    logic [15:0] next_cnt2;
    always_comb begin
        case (t2_src)
            CTP_T2_DIV12: tick2 = tick12;
            CTP_T2_EXT8:  tick2 = tickx;
            default:      tick2 = 1'b1;
        endcase
        tick2h    = t2h_sys | tick2;
        next_cnt2 = cnt2;
        ovf2l_ev  = 1'b0;
        ovf2h_ev  = 1'b0;
        if (!split2) begin
            if (run2 && tick2) begin
                ovf2l_ev  = &cnt2;
                next_cnt2 = ovf2l_ev ? rld2 : cnt2 + 16'h0001;
            end
        end else if (run2) begin
            if (tick2) begin
                ovf2l_ev = &cnt2[7:0];
                next_cnt2[7:0] = ovf2l_ev ? rld2[7:0] : cnt2[7:0] + 8'h01;
            end
            if (tick2h) begin
                ovf2h_ev = &cnt2[15:8];
                next_cnt2[15:8] = ovf2h_ev ? rld2[15:8] : cnt2[15:8] + 8'h01;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt2 <= CTP_RST_CNT;
        end else begin
            cnt2 <= (wr_en && avs_address_i == CTP_OFF_CNT2) ? m_cnt2[15:0] : next_cnt2;
        end
    end

    // sticky flags, write one to clear, a new event beats the clear
    logic [3:0] set_ev;
    logic [3:0] clr;
    logic [3:0] next_status;
    assign set_ev = {ovf2h_ev, ovf2l_ev, (mode0 == CTP_MSPLIT) ? th0_ev : ovf1_ev, ovf0_ev};
    assign clr    = (wr_en && avs_address_i == CTP_OFF_STATUS && avs_byteenable_i[0])
                    ? avs_writedata_i[3:0] : 4'h0;
    assign next_status = (status & ~clr) | set_ev;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status <= CTP_RST_STATUS;
            irq_o  <= 1'b0;
        end else begin
            status <= next_status;
            irq_o  <= |(next_status & mask);
        end
    end

    // baud tick on every second overflow of timer one
    logic half;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            half        <= 1'b0;
            baud_tick_o <= 1'b0;
        end else begin
            if (ovf1_ev) begin
                half <= ~half;
            end
            baud_tick_o <= ovf1_ev & half;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        if (avs_address_i == CTP_OFF_CLKCTL) begin
            rdata = {25'h0, clkctl};
        end else if (avs_address_i == CTP_OFF_MODE) begin
            rdata = {22'h0, modereg};
        end else if (avs_address_i == CTP_OFF_RUN) begin
            rdata = {28'h0, runreg};
        end else if (avs_address_i == CTP_OFF_CNT0) begin
            rdata = {16'h0, cnt0};
        end else if (avs_address_i == CTP_OFF_CNT1) begin
            rdata = {16'h0, cnt1};
        end else if (avs_address_i == CTP_OFF_CNT2) begin
            rdata = {16'h0, cnt2};
        end else if (avs_address_i == CTP_OFF_RLD2) begin
            rdata = {16'h0, rld2};
        end else if (avs_address_i == CTP_OFF_STATUS) begin
            rdata = {28'h0, status};
        end else if (avs_address_i == CTP_OFF_MASK) begin
            rdata = {28'h0, mask};
        end else begin
            rdata = 32'h0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0;
        end else if (rd_take) begin
            avs_readdata_o <= rdata;
        end
    end

endmodule : ctp_timers

// ==== ctp_timers_asserts.sv ====
// bus, interrupt and baud tick checks for the counter/timer block
`timescale 1ns/1ps
module ctp_timers_chk
    import ctp_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    input  wire logic [31:0] avs_readdata_o,
    input  wire logic        avs_waitrequest_o,
    input  wire logic        irq_o,
    input  wire logic        baud_tick_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_acc;
        (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    endsequence
    sequence s_rd_acc;
        s_acc ##0 avs_read_i;
    endsequence
    property p_answer;
        s_req |=> !avs_waitrequest_o;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after request");
    property p_one;
        s_acc |=> avs_waitrequest_o;
    endproperty
    a_one: assert property (p_one) else $error("wait low longer than one cycle");
    property p_cause;
        $fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i);
    endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_tick;
        baud_tick_o |=> !baud_tick_o;
    endproperty
    a_tick: assert property (p_tick) else $error("baud tick too wide");
    property p_unmapped;
        s_rd_acc ##0 (avs_address_i > CTP_OFF_MASK) |-> avs_readdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_resv;
        s_rd_acc ##0 (avs_address_i == CTP_OFF_STATUS || avs_address_i == CTP_OFF_MASK)
            |-> avs_readdata_o[31:4] == 28'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved status bits set");
    property p_rhold;
        $changed(avs_readdata_o) |-> !avs_waitrequest_o && avs_read_i;
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved without read");
    property p_mask_quiet;
        s_acc ##0 (avs_write_i && avs_address_i == CTP_OFF_MASK && avs_byteenable_i[0]
            && avs_writedata_i[3:0] == 4'h0) |=> ##1 !irq_o;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("irq with mask clear");
endmodule : ctp_timers_chk

bind ctp_timers ctp_timers_chk ctp_timers_chk_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o), .baud_tick_o(baud_tick_o));

// ==== ctp_far_end.sv ====
// far-side model: event pins, gating levels and external oscillator
`timescale 1ns/1ps
module ctp_far_end (
    input  wire logic       clock_i,
    input  wire logic [1:0] gate_i,
    input  wire logic       xen_i,
    output logic            ev0_o,
    output logic            ev1_o,
    output logic            gate_bit_zero_o,
    output logic            gate1_o,
    output logic            xclk_o
);
    logic ph;
    initial begin
        ev0_o = 1'b1;
        ev1_o = 1'b1;
        xclk_o = 1'b0;
        ph = 1'b0;
    end
    assign gate_bit_zero_o = gate_i[0];
    assign gate1_o = gate_i[1];
    // stands low when not enabled, so no stray edges reach the prescaler
    always @(posedge clock_i) begin
        ph <= ~ph;
        if (!xen_i) xclk_o <= 1'b0;
        else if (ph) xclk_o <= ~xclk_o;
    end
    // each level held hold cycles; one is the fastest legal source
    task automatic pulses(input int which, input int n, input int hold);
        repeat (n) begin
            repeat (hold) @(posedge clock_i);
            if (which == 0) ev0_o <= 1'b0;
            else ev1_o <= 1'b0;
            repeat (hold) @(posedge clock_i);
            if (which == 0) ev0_o <= 1'b1;
            else ev1_o <= 1'b1;
        end
    endtask : pulses
endmodule : ctp_far_end

// ==== test_counter_timers_with_prescaler.sv ====
// self-checking bench for the counter/timer block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_counter_timers_with_prescaler
    import ctp_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq, baud_tick, ev0, ev1, gt0, gt1, xclk;
    logic        xen = 1'b0;
    logic [1:0]  gate_cmd = 2'h0;
    logic [31:0] rd;
    int          err_count = 0;
    int          comparisons = 0;
    int          cyc = 0;

    ctp_timers ctp_timers_inst (.clock_i(clock), .rst_n_i(rst_n), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest), .event_input_zero_i(ev0),
        .event_input_one_i(ev1), .gating_input_zero_i(gt0), .gating_input_one_i(gt1),
        .external_oscillator_clock_i(xclk), .irq_o(irq), .baud_tick_o(baud_tick));
    ctp_far_end ctp_far_end_inst (.clock_i(clock), .gate_i(gate_cmd), .xen_i(xen),
        .ev0_o(ev0), .ev1_o(ev1), .gate_bit_zero_o(gt0), .gate1_o(gt1), .xclk_o(xclk));

    always #5 clock = ~clock;

    // longest test is the slow baud case, some two periods of 2304 cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // waits an edge first, so back-to-back calls never touch a strobe twice at once
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge clock);
            t++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        `CHK("bus answer", 2, t)
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic chk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rd)
    endtask : chk

    task automatic t_regs;
        for (int i = 0; i <= 9; i++) chk(6'(i * 4), 32'h0);
        wr(CTP_OFF_MASK, 32'hffffffff);
        chk(CTP_OFF_MASK, 32'h0000000f);
        wr(6'h24, 32'hffffffff);
        chk(6'h24, 32'h0);
        wr(CTP_OFF_MASK, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_ovf;
        wr(CTP_OFF_CLKCTL, 32'h04);
        wr(CTP_OFF_MODE, 32'h0);
        wr(CTP_OFF_CNT0, 32'hff1f);
        wr(CTP_OFF_RUN, 32'h1);
        repeat (8) @(posedge clock);
        wr(CTP_OFF_RUN, 32'h0);
        chk(CTP_OFF_STATUS, 32'h1);
        bus(1'b0, CTP_OFF_CNT0, 32'h0);
        `CHK("wrapped high byte", 8'h00, rd[15:8])
        `CHK("irq masked", 1'b0, irq)
        wr(CTP_OFF_MASK, 32'h1);
        repeat (2) @(posedge clock);
        `CHK("irq raised", 1'b1, irq)
        wr(CTP_OFF_STATUS, 32'h1);
        repeat (2) @(posedge clock);
        `CHK("irq cleared", 1'b0, irq)
        chk(CTP_OFF_STATUS, 32'h0);
        wr(CTP_OFF_MASK, 32'h0);
        $display("test overflow done");
    endtask : t_ovf

    // split timer zero: both halves on the system clock, so they must stay equal
    task automatic t_split;
        wr(CTP_OFF_CLKCTL, 32'h0c);
        wr(CTP_OFF_MODE, 32'h03);
        wr(CTP_OFF_CNT0, 32'hf0f0);
        wr(CTP_OFF_STATUS, 32'hf);
        wr(CTP_OFF_RUN, 32'h3);
        repeat (20) @(posedge clock);
        wr(CTP_OFF_RUN, 32'h0);
        chk(CTP_OFF_STATUS, 32'h3);
        bus(1'b0, CTP_OFF_CNT0, 32'h0);
        `CHK("split halves", rd[7:0], rd[15:8])
        `CHK("split high wrapped", 1'b1, rd[15:8] < 8'h10)
        $display("test split done");
    endtask : t_split

    // window is 480 cycles plus bus latency, so one tick of slack either way
    task automatic t_pre;
        int exp_cnt [4] = '{40, 120, 10, 15};
        for (int p = 0; p < 4; p++) begin
            xen <= (p == 3);
            wr(CTP_OFF_CLKCTL, 32'(p));
            wr(CTP_OFF_MODE, 32'h1);
            wr(CTP_OFF_CNT0, 32'h0);
            wr(CTP_OFF_RUN, 32'h1);
            repeat (480) @(posedge clock);
            wr(CTP_OFF_RUN, 32'h0);
            bus(1'b0, CTP_OFF_CNT0, 32'h0);
            `CHK("prescaled", 1'b1, (int'(rd[15:0]) - exp_cnt[p]) inside {[-1:1]})
        end
        xen <= 1'b0;
        $display("test prescale done");
    endtask : t_pre

    // select bits set on purpose: counter operation must ignore them
    task automatic t_evt;
        for (int k = 0; k < 2; k++) begin
            wr(CTP_OFF_CLKCTL, 32'h0c);
            wr(CTP_OFF_MODE, (k == 0) ? 32'h05 : 32'h50);
            wr((k == 0) ? CTP_OFF_CNT0 : CTP_OFF_CNT1, 32'h0);
            wr(CTP_OFF_RUN, 32'(1 << k));
            ctp_far_end_inst.pulses(k, 10, 2);
            repeat (6) @(posedge clock);
            chk((k == 0) ? CTP_OFF_CNT0 : CTP_OFF_CNT1, 32'd10);
            wr(CTP_OFF_RUN, 32'h0);
        end
        $display("test events done");
    endtask : t_evt

    task automatic t_gate;
        wr(CTP_OFF_CLKCTL, 32'h04);
        wr(CTP_OFF_MODE, 32'h109);
        wr(CTP_OFF_CNT0, 32'h0);
        wr(CTP_OFF_RUN, 32'h1);
        repeat (20) @(posedge clock);
        chk(CTP_OFF_CNT0, 32'h0);
        gate_cmd <= 2'h1;
        repeat (20) @(posedge clock);
        wr(CTP_OFF_RUN, 32'h0);
        bus(1'b0, CTP_OFF_CNT0, 32'h0);
        `CHK("gated count", 1'b1, rd[15:0] > 16'd16)
        gate_cmd <= 2'h0;
        $display("test gate done");
    endtask : t_gate

    task automatic t_baud;
        int per [3] = '{106, 212, 2304};
        logic [7:0] rl [3] = '{8'hcb, 8'h96, 8'ha0};
        int n;
        wr(CTP_OFF_MODE, 32'h20);
        for (int i = 0; i < 3; i++) begin
            wr(CTP_OFF_CLKCTL, (i < 2) ? 32'h08 : 32'h00);
            wr(CTP_OFF_CNT1, {16'h0, rl[i], rl[i]});
            wr(CTP_OFF_RUN, 32'h2);
            n = 0;
            while (baud_tick !== 1'b1 && n < 6000) begin
                @(posedge clock);
                n++;
            end
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (baud_tick !== 1'b1 && n < 6000);
            `CHK("baud period", per[i], n)
            wr(CTP_OFF_RUN, 32'h0);
        end
        $display("test baud done");
    endtask : t_baud

    task automatic t_t2;
        // third pass runs over twelve: too slow to reach the wrap
        for (int s = 0; s < 3; s++) begin
            wr(CTP_OFF_CLKCTL, (s == 2) ? 32'h00 : 32'h60);
            wr(CTP_OFF_RLD2, (s == 1) ? 32'hf0f0 : 32'hfff0);
            wr(CTP_OFF_CNT2, (s == 1) ? 32'hf0f0 : 32'hfff0);
            wr(CTP_OFF_STATUS, 32'hf);
            wr(CTP_OFF_RUN, (s == 1) ? 32'hc : 32'h4);
            repeat (40) @(posedge clock);
            wr(CTP_OFF_RUN, 32'h0);
            bus(1'b0, CTP_OFF_CNT2, 32'h0);
            `CHK("t2 reloaded", 4'hf, rd[15:12])
            chk(CTP_OFF_STATUS, (s == 0) ? 32'h4 : (s == 1) ? 32'hc : 32'h0);
        end
        $display("test timer two done");
    endtask : t_t2

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_ovf();
        t_split();
        t_pre();
        t_evt();
        t_gate();
        t_baud();
        t_t2();
        wrap_up();
    end
endmodule : test_counter_timers_with_prescaler
